// *** core/mm_memory_mover.v ***
// Multi-channel memory mover between data RAM and peripheral data registers
//
// Function
// - Moves bytes without processor per-byte work
// - Seven channels, each with own registers
// - Each channel selects one of nine functions
// - Half-length and full-length flags per channel
// - Offset counts zero to size minus one
// - Offset restarts at zero; wrap bit keeps the channel enabled
// - Mode register indirect through channel select
`include "mm_defines.vh"
`default_nettype none
module mm_memory_mover #(
  parameter NCH = 7,
  parameter AW = 16
) (
  input wire SYS_CLK,
  input wire RST_N,
  input wire [7:0] SFR_ADDR,
  input wire SFR_WR,
  input wire SFR_RD,
  input wire [7:0] SFR_WDATA,
  output reg [7:0] SFR_RDATA,
  input wire [`MM_FN_COUNT-1:0] PER_REQ,
  output reg [`MM_FN_COUNT-1:0] PER_ACK,
  output wire PER_RD,
  output wire [3:0] PER_RFUNC,
  input wire [7:0] PER_RDATA,
  output wire PER_WR,
  output wire [3:0] PER_WFUNC,
  output wire [7:0] PER_WDATA,
  input wire PER_WREADY,
  output wire RAM_RD,
  output wire [AW-1:0] RAM_RADDR,
  input wire [7:0] RAM_RDATA,
  output wire RAM_WR,
  output wire [AW-1:0] RAM_WADDR,
  output wire [7:0] RAM_WDATA,
  output wire [NCH-1:0] HALF_FLAGS,
  output wire [NCH-1:0] FULL_FLAGS
);
  localparam EW = 1 + 4 + AW + 8;
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_CAPT = 2'b10;

  ////////////////////////////////////////////////////////////////////////////
  // Decoding shared by the issue and capture paths
  function to_ram;
    input [3:0] fn;
    begin
      to_ram = (fn == `MM_FN_CODEC_TO_RAM) || (fn == `MM_FN_SERIAL_TO_RAM) || (fn == `MM_FN_CIPHER_TO_RAM);
    end
  endfunction

  function fn_valid;
    input [3:0] fn;
    begin
      fn_valid = (fn < `MM_FN_COUNT);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Channel registers
  reg [2:0] sel_q;
  reg [3:0] func_q [0:NCH-1];
  reg [7:0] ctrl_q [0:NCH-1];
  reg [7:0] mode_q [0:NCH-1];
  reg [AW-1:0] base_q [0:NCH-1];
  reg [AW-1:0] size_q [0:NCH-1];
  reg [AW-1:0] offs_q [0:NCH-1];
  reg [NCH-1:0] half_q;
  reg [NCH-1:0] full_q;
  reg [1:0] state_q;
  reg [2:0] cur_q;
  reg [NCH-1:0] hit_half;
  reg [NCH-1:0] hit_full;

  // Buffer of two outgoing bytes
  reg [EW-1:0] buf_q [0:1];
  reg [1:0] cnt_q;
  reg rp_q;
  wire buf_in_ready = (cnt_q != 2'd2);
  wire buf_out_valid = (cnt_q != 2'd0);
  wire [EW-1:0] head = buf_q[rp_q];
  wire head_to_ram = head[EW-1];
  wire buf_out_ready = head_to_ram | PER_WREADY;
  wire pop = buf_out_valid & buf_out_ready;

  ////////////////////////////////////////////////////////////////////////////
  // Channel pick: lowest enabled channel whose peripheral requests
  reg pick_ok;
  reg [2:0] pick;
  integer i;
  always @* begin
    pick_ok = 1'b0;
    pick = 3'd0;
    for (i = NCH - 1; i >= 0; i = i - 1) begin
      if (ctrl_q[i][`MM_CTRL_ENABLE_BIT] && fn_valid(func_q[i]) && PER_REQ[func_q[i]]) begin
        pick_ok = 1'b1;
        pick = i[2:0];
      end
    end
  end

  wire issue = (state_q == ST_IDLE) & pick_ok & buf_in_ready;
  wire [3:0] pick_fn = func_q[pick];
  wire pick_to_ram = to_ram(pick_fn);
  wire [3:0] cur_fn = func_q[cur_q];
  wire cur_to_ram = to_ram(cur_fn);
  wire [AW-1:0] cur_addr = base_q[cur_q] + offs_q[cur_q];
  wire [AW-1:0] cur_next = offs_q[cur_q] + {{(AW-1){1'b0}}, 1'b1};
  wire cur_last = (cur_next >= size_q[cur_q]);
  wire cur_half = (cur_next == (size_q[cur_q] >> 1));

  // Source read strobes, one byte per granted request
  assign RAM_RD = issue & ~pick_to_ram;
  assign RAM_RADDR = base_q[pick] + offs_q[pick];
  assign PER_RD = issue & pick_to_ram;
  assign PER_RFUNC = pick_fn;

  // Acknowledge pulse returned to the requesting peripheral
  always @* begin
    PER_ACK = {`MM_FN_COUNT{1'b0}};
    if (issue) begin
      PER_ACK[pick_fn] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: issue read, then capture byte into buffer
  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      state_q <= ST_IDLE;
      cur_q <= 3'd0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (issue) begin
            state_q <= ST_CAPT;
            cur_q <= pick;
          end
        end
        ST_CAPT: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  wire capt = (state_q == ST_CAPT);
  wire [7:0] capt_data = cur_to_ram ? PER_RDATA : RAM_RDATA;

  ////////////////////////////////////////////////////////////////////////////
  // Two-entry buffer; peripheral stall holds the head
  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      cnt_q <= 2'd0;
      rp_q <= 1'b0;
      buf_q[0] <= {EW{1'b0}};
      buf_q[1] <= {EW{1'b0}};
    end else begin
      // New byte goes to the tail; a same-cycle pop only moves the head
      if (capt) begin
        buf_q[rp_q ^ (cnt_q != 2'd0)] <= {cur_to_ram, cur_fn, cur_addr, capt_data};
      end
      if (pop) begin
        rp_q <= ~rp_q;
      end
      cnt_q <= cnt_q + {1'b0, capt} - {1'b0, pop};
    end
  end

  assign RAM_WR = buf_out_valid & head_to_ram;
  assign RAM_WADDR = head[AW+7:8];
  assign RAM_WDATA = head[7:0];
  assign PER_WR = buf_out_valid & ~head_to_ram;
  assign PER_WFUNC = head[EW-2:AW+8];
  assign PER_WDATA = head[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel event decode for this capture
  integer k;
  always @* begin
    hit_half = {NCH{1'b0}};
    hit_full = {NCH{1'b0}};
    for (k = 0; k < NCH; k = k + 1) begin
      if (capt && cur_q == k[2:0]) begin
        hit_half[k] = cur_half;
        hit_full[k] = cur_last;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes and channel counters
  wire sw = SFR_WR;
  integer j;
  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      sel_q <= 3'd0;
      half_q <= {NCH{1'b0}};
      full_q <= {NCH{1'b0}};
      for (j = 0; j < NCH; j = j + 1) begin
        func_q[j] <= `MM_FUNC_RESET;
        ctrl_q[j] <= `MM_CTRL_RESET;
        mode_q[j] <= `MM_MODE_RESET;
        base_q[j] <= {AW{1'b0}};
        size_q[j] <= {AW{1'b0}};
        offs_q[j] <= {AW{1'b0}};
      end
    end else begin
      if (sw && SFR_ADDR == `MM_ADDR_CHANNEL_SELECT && SFR_WDATA[2:0] < NCH) begin
        sel_q <= SFR_WDATA[2:0];
      end
      // Indirect writes reach the selected channel only
      if (sw) begin
        case (SFR_ADDR)
          `MM_ADDR_CHANNEL_FUNC: func_q[sel_q] <= SFR_WDATA[3:0];
          `MM_ADDR_CHANNEL_CTRL: ctrl_q[sel_q] <= SFR_WDATA;
          `MM_ADDR_DMA_CHANNEL_MODE: mode_q[sel_q] <= {7'h00, SFR_WDATA[`MM_MODE_WRAP_BIT]};
          `MM_ADDR_BASE_LO: base_q[sel_q][7:0] <= SFR_WDATA;
          `MM_ADDR_BASE_HI: base_q[sel_q][AW-1:8] <= SFR_WDATA[AW-9:0];
          `MM_ADDR_SIZE_LO: size_q[sel_q][7:0] <= SFR_WDATA;
          `MM_ADDR_SIZE_HI: size_q[sel_q][AW-1:8] <= SFR_WDATA[AW-9:0];
          `MM_ADDR_OFFSET_LO: offs_q[sel_q][7:0] <= SFR_WDATA;
          `MM_ADDR_OFFSET_HI: offs_q[sel_q][AW-1:8] <= SFR_WDATA[AW-9:0];
          default: begin
          end
        endcase
      end
      // Offset advance, wrap or stop after each captured byte
      if (capt) begin
        if (cur_last) begin
          offs_q[cur_q] <= {AW{1'b0}};
          if (!mode_q[cur_q][`MM_MODE_WRAP_BIT]) begin
            ctrl_q[cur_q][`MM_CTRL_ENABLE_BIT] <= 1'b0;
          end
        end else begin
          offs_q[cur_q] <= cur_next;
        end
      end
      // Write one clears a flag; a same-cycle event wins
      half_q <= (half_q & ~((sw && SFR_ADDR == `MM_ADDR_HALF_FLAGS) ? SFR_WDATA[NCH-1:0] : {NCH{1'b0}})) | hit_half;
      full_q <= (full_q & ~((sw && SFR_ADDR == `MM_ADDR_FULL_FLAGS) ? SFR_WDATA[NCH-1:0] : {NCH{1'b0}})) | hit_full;
    end
  end

  assign HALF_FLAGS = half_q;
  assign FULL_FLAGS = full_q;

  ////////////////////////////////////////////////////////////////////////////
  // Read data, registered one cycle after the read strobe
  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      SFR_RDATA <= 8'h00;
    end else if (SFR_RD) begin
      case (SFR_ADDR)
        `MM_ADDR_CHANNEL_SELECT: SFR_RDATA <= {5'h00, sel_q};
        `MM_ADDR_CHANNEL_FUNC: SFR_RDATA <= {4'h0, func_q[sel_q]};
        `MM_ADDR_CHANNEL_CTRL: SFR_RDATA <= ctrl_q[sel_q];
        `MM_ADDR_DMA_CHANNEL_MODE: SFR_RDATA <= mode_q[sel_q];
        `MM_ADDR_BASE_LO: SFR_RDATA <= base_q[sel_q][7:0];
        `MM_ADDR_BASE_HI: SFR_RDATA <= base_q[sel_q][AW-1:8];
        `MM_ADDR_SIZE_LO: SFR_RDATA <= size_q[sel_q][7:0];
        `MM_ADDR_SIZE_HI: SFR_RDATA <= size_q[sel_q][AW-1:8];
        `MM_ADDR_OFFSET_LO: SFR_RDATA <= offs_q[sel_q][7:0];
        `MM_ADDR_OFFSET_HI: SFR_RDATA <= offs_q[sel_q][AW-1:8];
        `MM_ADDR_HALF_FLAGS: SFR_RDATA <= {1'b0, half_q};
        `MM_ADDR_FULL_FLAGS: SFR_RDATA <= {1'b0, full_q};
        default: SFR_RDATA <= 8'h00;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** core/mm_defines.vh ***
// Register addresses, field positions, encodings and reset values of the memory mover
`ifndef MM_DEFINES_VH
`define MM_DEFINES_VH
// Register addresses on the special function register port
`define MM_ADDR_CHANNEL_SELECT 8'hD0
`define MM_ADDR_CHANNEL_FUNC 8'hD2
`define MM_ADDR_CHANNEL_CTRL 8'hD3
`define MM_ADDR_BASE_LO 8'hD4
`define MM_ADDR_BASE_HI 8'hD5
`define MM_ADDR_DMA_CHANNEL_MODE 8'hD6
`define MM_ADDR_SIZE_LO 8'hD7
`define MM_ADDR_SIZE_HI 8'hD9
`define MM_ADDR_OFFSET_LO 8'hDA
`define MM_ADDR_OFFSET_HI 8'hDB
`define MM_ADDR_HALF_FLAGS 8'hDC
`define MM_ADDR_FULL_FLAGS 8'hDD
// Field positions
`define MM_MODE_WRAP_BIT 0
`define MM_CTRL_ENABLE_BIT 0
// Reset values
`define MM_MODE_RESET 8'h00
`define MM_CTRL_RESET 8'h00
`define MM_FUNC_RESET 4'hF
// Transfer functions
`define MM_FN_RAM_TO_CODEC 4'h0
`define MM_FN_CODEC_TO_RAM 4'h1
`define MM_FN_RAM_TO_CHECKSUM 4'h2
`define MM_FN_RAM_TO_SERIAL 4'h3
`define MM_FN_SERIAL_TO_RAM 4'h4
`define MM_FN_RAM_TO_KEY 4'h5
`define MM_FN_RAM_TO_BLOCK 4'h6
`define MM_FN_RAM_TO_XOR 4'h7
`define MM_FN_CIPHER_TO_RAM 4'h8
`define MM_FN_COUNT 9
`endif

// *** bench/mm_checker_sva.sv ***
// Port assertions for the memory mover
`default_nettype none
`include "mm_defines.vh"
module mm_checker #(
  parameter NCH = 7
) (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic SFR_WR,
  input wire logic SFR_RD,
  input wire logic PER_RD,
  input wire logic RAM_RD,
  input wire logic PER_WR,
  input wire logic PER_WREADY,
  input wire logic [7:0] SFR_ADDR,
  input wire logic [7:0] SFR_RDATA,
  input wire logic [7:0] PER_WDATA,
  input wire logic [3:0] PER_WFUNC,
  input wire logic [8:0] PER_REQ,
  input wire logic [8:0] PER_ACK,
  input wire logic [NCH-1:0] HALF_FLAGS,
  input wire logic [NCH-1:0] FULL_FLAGS
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  // Grant step and the quiet step that must follow it
  sequence s_grant; |PER_ACK; endsequence
  sequence s_quiet; PER_ACK == 9'h000; endsequence
  // Grants, reads and offered bytes
  AST_ONE_GRANT: assert property ($onehot0(PER_ACK)) else $error("two grants at once");
  AST_GRANT_REQ: assert property ((PER_ACK & ~PER_REQ) == 9'h000) else $error("grant without request");
  AST_GRANT_READ: assert property (s_grant |-> RAM_RD != PER_RD) else $error("grant without one read");
  AST_READ_GRANT: assert property ((RAM_RD || PER_RD) |-> s_grant) else $error("read without grant");
  AST_SPACING: assert property (s_grant |=> s_quiet) else $error("grants too close");
  AST_WR_HOLD: assert property (PER_WR && !PER_WREADY |=> PER_WR && $stable(PER_WDATA) && $stable(PER_WFUNC))
    else $error("offered byte dropped");
  // Flags stay set until written clear; a read of unmapped address D1 returns zero
  AST_FULL_STICKY: assert property (!(SFR_WR && SFR_ADDR == `MM_ADDR_FULL_FLAGS) |=>
    (FULL_FLAGS & $past(FULL_FLAGS)) == $past(FULL_FLAGS)) else $error("full flag lost");
  AST_HALF_STICKY: assert property (!(SFR_WR && SFR_ADDR == `MM_ADDR_HALF_FLAGS) |=>
    (HALF_FLAGS & $past(HALF_FLAGS)) == $past(HALF_FLAGS)) else $error("half flag lost");
  AST_UNMAPPED: assert property (SFR_RD && SFR_ADDR == 8'hD1 |=> SFR_RDATA == 8'h00) else $error("bad read");
endmodule
bind mm_memory_mover mm_checker #(.NCH(NCH)) i_chk (
  .SYS_CLK(SYS_CLK),
  .RST_N(RST_N),
  .SFR_WR(SFR_WR),
  .SFR_RD(SFR_RD),
  .PER_RD(PER_RD),
  .RAM_RD(RAM_RD),
  .PER_WR(PER_WR),
  .PER_WREADY(PER_WREADY),
  .SFR_ADDR(SFR_ADDR),
  .SFR_RDATA(SFR_RDATA),
  .PER_WDATA(PER_WDATA),
  .PER_WFUNC(PER_WFUNC),
  .PER_REQ(PER_REQ),
  .PER_ACK(PER_ACK),
  .HALF_FLAGS(HALF_FLAGS),
  .FULL_FLAGS(FULL_FLAGS)
);
`default_nettype wire

// *** bench/mm_peer_model.sv ***
// Peripheral and data RAM model facing the memory mover
`default_nettype none
module mm_peer_model (
  input wire logic SYS_CLK,
  input wire logic PER_RD,
  input wire logic PER_WR,
  input wire logic RAM_RD,
  input wire logic RAM_WR,
  input wire logic stall,
  input wire logic [8:0] req_en,
  input wire logic [8:0] PER_ACK,
  input wire logic [3:0] PER_RFUNC,
  input wire logic [3:0] PER_WFUNC,
  input wire logic [7:0] PER_WDATA,
  input wire logic [7:0] RAM_WDATA,
  input wire logic [15:0] RAM_RADDR,
  input wire logic [15:0] RAM_WADDR,
  output logic [8:0] PER_REQ,
  output logic [7:0] PER_RDATA,
  output logic [7:0] RAM_RDATA,
  output logic PER_WREADY
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:255];
  logic [7:0] got [0:15];
  logic [8:0] ack_q = 9'h000;
  logic [7:0] src_q = 8'h00;
  int got_n = 0;
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = i[7:0] ^ 8'hA5;
    PER_RDATA = 8'h00;
    RAM_RDATA = 8'h00;
    PER_WREADY = 1'b0;
  end
  // Request drops for one cycle after each grant
  assign PER_REQ = req_en & ~ack_q;
  // Answers a cycle after the strobe, a toggling pattern otherwise
  always @(posedge SYS_CLK) begin
    ack_q <= PER_ACK;
    RAM_RDATA <= RAM_RD ? mem[RAM_RADDR[7:0]] : ~RAM_RDATA;
    PER_RDATA <= PER_RD ? {PER_RFUNC, src_q[3:0]} : ~PER_RDATA;
    if (PER_RD) src_q <= src_q + 8'h01;
    if (RAM_WR) mem[RAM_WADDR[7:0]] <= RAM_WDATA;
    PER_WREADY <= !stall;
    if (PER_WR && PER_WREADY) begin
      got[got_n[3:0]] <= PER_WDATA;
      got_n <= got_n + 1;
    end
  end
endmodule
`default_nettype wire

// *** bench/dma_multichannel_xfer_bench.sv ***
// Self-checking bench of the memory mover
`default_nettype none
`include "mm_defines.vh"
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin fails++; $display("FAIL t=%0t got %h want %h", $time, a, e); end end
module dma_multichannel_xfer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic SYS_CLK = 0, RST_N = 0, SFR_WR = 0, SFR_RD = 0, stall = 0;
  logic [7:0] SFR_ADDR = 8'h00, SFR_WDATA = 8'h00;
  logic [8:0] req_en = 9'h000;
  wire [7:0] SFR_RDATA, PER_RDATA, PER_WDATA, RAM_RDATA, RAM_WDATA;
  wire [8:0] PER_REQ, PER_ACK;
  wire [3:0] PER_RFUNC, PER_WFUNC;
  wire [15:0] RAM_RADDR, RAM_WADDR;
  wire [6:0] HALF_FLAGS, FULL_FLAGS;
  wire PER_RD, PER_WR, PER_WREADY, RAM_RD, RAM_WR;
  int fails = 0, samples_checked = 0;
  // Rows: write flag, address, data or expected read
  logic [16:0] rows [0:11] = '{17'h0D600, 17'h0D300, 17'h0D100, 17'h1D002, 17'h1D601, 17'h0D601,
    17'h1D003, 17'h0D600, 17'h1D007, 17'h0D003, 17'h1D002, 17'h0D601};
  mm_memory_mover i_dut (.*);
  mm_peer_model i_peer (.*);
  initial forever #4 SYS_CLK = ~SYS_CLK;
  ////////////////////////////////////////////////////////////////////////
  // Register port cycles
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    SFR_ADDR <= a;
    SFR_WDATA <= d;
    SFR_WR <= 1'b1;
    @(posedge SYS_CLK);
    SFR_WR <= 1'b0;
    @(posedge SYS_CLK);
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] q);
    SFR_ADDR <= a;
    SFR_RD <= 1'b1;
    @(posedge SYS_CLK);
    SFR_RD <= 1'b0;
    @(posedge SYS_CLK);
    q = SFR_RDATA;
  endtask
  task automatic tally_and_finish;
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Watchdog well beyond the expected run
  initial begin
    #20000;
    fails++;
    tally_and_finish();
  end
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [7:0] q;
    repeat (4) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    @(posedge SYS_CLK);
    foreach (rows[i]) begin
      if (rows[i][16]) reg_wr(rows[i][15:8], rows[i][7:0]);
      else begin
        reg_rd(rows[i][15:8], q);
        `CHK(q, rows[i][7:0])
      end
    end
    // Channel 2, RAM to serial port, size 4, wrap on, receiver stalled
    reg_wr(8'hD2, 8'h03);
    reg_wr(8'hD4, 8'h10);
    reg_wr(8'hD7, 8'h04);
    stall <= 1'b1;
    req_en <= 9'h008;
    reg_wr(8'hD3, 8'h01);
    repeat (12) @(posedge SYS_CLK);
    `CHK(i_peer.got_n, 0)
    `CHK({PER_WR, PER_WFUNC, PER_WDATA}, {1'b1, `MM_FN_RAM_TO_SERIAL, 8'hB5})
    stall <= 1'b0;
    for (int k = 0; k < 100 && i_peer.got_n < 6; k++) @(posedge SYS_CLK);
    for (int i = 0; i < 6; i++) `CHK(i_peer.got[i], (8'h10 + i[7:0] % 8'h04) ^ 8'hA5)
    req_en <= 9'h000;
    repeat (6) @(posedge SYS_CLK);
    `CHK({HALF_FLAGS[2], FULL_FLAGS[2]}, 2'b11)
    reg_wr(8'hDD, 8'h04);
    `CHK(FULL_FLAGS[2], 1'b0)
    // Channel 0, serial port to RAM, size 2, no wrap
    reg_wr(8'hD0, 8'h00);
    reg_wr(8'hD2, 8'h04);
    reg_wr(8'hD4, 8'h40);
    reg_wr(8'hD7, 8'h02);
    req_en <= 9'h010;
    reg_wr(8'hD3, 8'h01);
    repeat (20) @(posedge SYS_CLK);
    `CHK({i_peer.mem[64], i_peer.mem[65], i_peer.mem[66]}, 24'h4041E7)
    `CHK({HALF_FLAGS[0], FULL_FLAGS[0]}, 2'b11)
    reg_rd(8'hD3, q);
    `CHK(q, 8'h00)
    reg_rd(8'hDA, q);
    `CHK(q, 8'h00)
    // Reset in mid-run returns registers and flags to their reset values
    req_en <= 9'h000;
    RST_N <= 1'b0;
    repeat (4) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    @(posedge SYS_CLK);
    `CHK({HALF_FLAGS, FULL_FLAGS}, 14'h0000)
    reg_rd(8'hD2, q);
    `CHK(q, 8'h0F)
    reg_rd(8'hD6, q);
    `CHK(q, 8'h00)
    tally_and_finish();
  end
endmodule
`default_nettype wire
